//--- inc/led_sync_dim_pkg.sv
// Constants for the boost clock select and dimming control block
package led_sync_dim_pkg;
   localparam int CLK_KHZ       = 40000;
   // Oscillator range and fault clamp, frequencies in kHz
   localparam int F_MIN_KHZ     = 580;
   localparam int F_MAX_KHZ     = 2300;
   localparam int F_CLAMP_KHZ   = 3500;
   localparam int PER_W         = 7;
   // Longest period still at or above the range floor: round down
   localparam logic [6:0] PER_MAX =
      7'(CLK_KHZ / F_MIN_KHZ);
   // Shortest period never above the clamp: round up
   localparam logic [6:0] PER_CLAMP =
      7'((CLK_KHZ + F_CLAMP_KHZ - 1) / F_CLAMP_KHZ);
   // External clock loss timeout, longest time: round down
   localparam int SYNC_LOSS_NS  = 7000;
   localparam int SYNC_LOSS_CYC = SYNC_LOSS_NS * CLK_KHZ / 1000000;
   localparam int SYNC_CNT_W    = 9;
   // Restart hold in clock-loss shutdown, least time: round up
   localparam int RESTART_NS    = 5000;
   localparam int RESTART_CYC   =
      (RESTART_NS * CLK_KHZ + 999999) / 1000000;
   // Least width of the first enable pulse, least time: round up
   localparam int EN_FIRST_NS   = 1000;
   localparam int EN_FIRST_CYC  =
      (EN_FIRST_NS * CLK_KHZ + 999999) / 1000000;
   // Enable low time that selects low power mode
   localparam int LOW_POWER_MS  = 65;
   localparam int LOW_POWER_CYC = LOW_POWER_MS * CLK_KHZ;
   // Delay before a new trim duty reaches the LED current
   localparam int TRIM_DELAY_MS = 4;
   localparam int TRIM_DELAY_CYC = TRIM_DELAY_MS * CLK_KHZ;
   // Trim duty window: 2**TRIM_WIN_W cycles, level in LEVEL_W bits
   localparam int TRIM_WIN_W    = 12;
   localparam int LEVEL_W       = 8;
   localparam logic [7:0] LEVEL_FULL = 8'hFF;
   // Rising edges seen before the external clock is taken
   localparam logic [1:0] SYNC_LOCK_EDGES = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE, ST_RUN, ST_SHDN, ST_LOWPWR
   } ctrl_state_t;
endpackage

//--- verilog/led_sync_dim_ctrl.sv
// Boost clock select, clock-loss shutdown and LED dimming control
`timescale 1ns/100ps
// Operation
// [R1] Internal switching clock spans 580 kHz to 2.3 MHz, set by resistor.
// [R2] Switching frequency is clamped to at most 3.5 MHz under faults.
// [R3] A frequency-set pin shorted to ground while running shuts down.
// [R4] No power-up while the frequency-set pin is held low; the code still starts with the pin low once a sync clock is taken.
// [R5] Power-up tried once the pin rises near 1 V or sync is seen.
// [R6] Changeover to the external clock causes no LED current step.
// [R7] External clock high and low phases each last at least 150 ns.
// [R8] External clock duty 33 to 66 percent at 2.2 MHz, wider lower.
// [R9] Losing the external clock falls back to the internal frequency.
// [R10] Fallback pauses switching for no more than about 7 us.
// [R11] External clock low longer than 7 us enters shutdown.
// [R12] That shutdown stops boost, opens disconnect, stops LED sinks.
// [R13] Host holds enable low 65 ms to select low power mode.
// [R14] Pin released after 5 us of that shutdown restarts by soft start.
// [R15] Enable high: run, every enabled LED sinks full current.
// [R16] Enable low: boost and sinks off, compensation floated, core alive.
// [R17] Enable edge reaches the LED current within about 500 ns.
// [R18] Host applies enable dimming at 200 Hz to 1 kHz.
// [R19] LED current falls inversely with trim input duty.
// [R20] Host drives trim input at 20 kHz to 1 MHz.
// [R21] Unused trim input is grounded; trimmed maximum has 5 % margin.
// [R22] Trim duty changes reach the LED current after several ms.
// [R23] Start needs enable first pulse width and supply above UVLO.
// [R24] External clock loss found by timing its phases, no edge in time.
module led_sync_dim_ctrl #(
   parameter int LOW_POWER_CYC  = led_sync_dim_pkg::LOW_POWER_CYC,
   parameter int TRIM_DELAY_CYC = led_sync_dim_pkg::TRIM_DELAY_CYC
) (
   input  wire logic       REF_CLK,          // 40 MHz clock
   input  wire logic       RST_B,            // Async reset, active low
   input  wire logic       EN_PWM,           // Enable and dimming pin
   input  wire logic       SYNC_IN,          // External switching clock
   input  wire logic       FREQ_SET_HIGH,    // Set pin above about 1 V
   input  wire logic       FREQ_SET_SHORT,   // Set pin shorted to ground
   input  wire logic [6:0] FREQ_SET_PERIOD,  // Resistor-set period, cycles
   input  wire logic       UVLO_OK,          // Supply above start level
   input  wire logic       CURRENT_TRIM_PWM, // Digital current trim input
   output logic            SW_CLK,           // Boost switch drive
   output logic            BOOST_EN,         // Boost converter enable
   output logic            LED_SINK_EN,      // LED current sinks enable
   output logic            DISCONNECT_ON,    // Input disconnect closed
   output logic            COMP_FLOAT,       // Compensation node floated
   output logic            CORE_ALIVE,       // Critical circuits powered
   output logic            SOFT_START,       // One-cycle soft start pulse
   output logic            EXT_CLK_SEL,      // External clock in use
   output logic            CLK_LOSS_SHDN,    // Clock-loss shutdown state
   output logic            LOW_POWER,        // Low power mode
   output logic [7:0]      ILED_LEVEL        // LED current, FF is full
);
   localparam int LPW = $clog2(LOW_POWER_CYC + 1);
   localparam int TDW = $clog2(TRIM_DELAY_CYC + 1);
   localparam int SCW = led_sync_dim_pkg::SYNC_CNT_W;
   localparam logic [SCW-1:0] LOSS_CYC =
      SCW'(led_sync_dim_pkg::SYNC_LOSS_CYC);
   localparam logic [SCW-1:0] RST_CYC =
      SCW'(led_sync_dim_pkg::RESTART_CYC);
   localparam logic [6:0] EN_MIN =
      7'(led_sync_dim_pkg::EN_FIRST_CYC);
   localparam logic [LPW-1:0] LP_CYC = LPW'(LOW_POWER_CYC);
   localparam logic [TDW-1:0] TD_CYC = TDW'(TRIM_DELAY_CYC);
   localparam int TWW = led_sync_dim_pkg::TRIM_WIN_W;

   // Pin synchronisers: first stages feed only second stages
   logic       en_s1, en_s2, sy_s1, sy_s2, fh_s1, fh_s2;
   logic       fs_s1, fs_s2, uv_s1, uv_s2, tr_s1, tr_s2;
   logic [6:0] per_s1, per_s2, per_s3, per_q;
   logic       sy_d;

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         {en_s1, en_s2, sy_s1, sy_s2, fh_s1, fh_s2} <= 6'h00;
         {fs_s1, fs_s2, uv_s1, uv_s2, tr_s1, tr_s2} <= 6'h00;
         per_s1 <= 7'h00;
         per_s2 <= 7'h00;
         per_s3 <= 7'h00;
         per_q  <= 7'h00;
         sy_d   <= 1'b0;
      end else begin
         en_s1  <= EN_PWM;
         en_s2  <= en_s1;
         sy_s1  <= SYNC_IN;
         sy_s2  <= sy_s1;
         fh_s1  <= FREQ_SET_HIGH;
         fh_s2  <= fh_s1;
         fs_s1  <= FREQ_SET_SHORT;
         fs_s2  <= fs_s1;
         uv_s1  <= UVLO_OK;
         uv_s2  <= uv_s1;
         tr_s1  <= CURRENT_TRIM_PWM;
         tr_s2  <= tr_s1;
         per_s1 <= FREQ_SET_PERIOD;
         per_s2 <= per_s1;
         per_s3 <= per_s2;
         // Word taken only when two samples agree, so no torn code
         if (per_s2 == per_s3)
            per_q <= per_s2;
         sy_d   <= sy_s2;
      end
   end

   // Clock source selection and switching drive
   logic [SCW-1:0] lo_cnt, hi_cnt, next_lo_cnt, next_hi_cnt;
   logic [1:0]     edges, next_edges;
   logic           ext_sel, next_ext_sel;
   logic [6:0]     sw_cnt, next_sw_cnt, per;
   logic           sync_rise, loss_low, int_sw, ext_sw;

   always_comb begin
      sync_rise    = sy_s2 & ~sy_d;
      next_lo_cnt  = lo_cnt;
      next_hi_cnt  = hi_cnt;
      next_edges   = edges;
      next_ext_sel = ext_sel;
      loss_low     = 1'b0;
      // Phase timers saturate at the loss timeout
      if (sy_s2 != sy_d) begin
         next_lo_cnt = '0;
         next_hi_cnt = '0;
      end else if (sy_s2 && hi_cnt != LOSS_CYC) begin
         next_hi_cnt = hi_cnt + 1'b1;
      end else if (!sy_s2 && lo_cnt != LOSS_CYC) begin
         next_lo_cnt = lo_cnt + 1'b1;
      end
      if (ext_sel && !sy_s2 && lo_cnt == LOSS_CYC - 1'b1) begin
         loss_low     = 1'b1;                            // [R11] [R24]
         next_ext_sel = 1'b0;
         next_edges   = 2'h0;
      end else if (ext_sel && sy_s2 && hi_cnt == LOSS_CYC - 1'b1) begin
         next_ext_sel = 1'b0;                            // [R9] [R24]
         next_edges   = 2'h0;
      end else if (sync_rise) begin
         if (edges == led_sync_dim_pkg::SYNC_LOCK_EDGES)
            next_ext_sel = 1'b1;
         else
            next_edges = edges + 1'b1;
      end
      // Out-of-range codes clamp to the legal oscillator periods
      if (per_q < led_sync_dim_pkg::PER_CLAMP)
         per = led_sync_dim_pkg::PER_CLAMP;              // [R2]
      else if (per_q > led_sync_dim_pkg::PER_MAX)
         per = led_sync_dim_pkg::PER_MAX;                // [R1]
      else
         per = per_q;                                    // [R1]
      // Internal period restarts at each clock source change and at its own end
      if (next_ext_sel != ext_sel || sw_cnt >= per - 7'h01)
         next_sw_cnt = 7'h00;
      else
         next_sw_cnt = sw_cnt + 7'h01;
      int_sw = sw_cnt < (per >> 1);
      // On-time bounded, so a stuck-high clock pauses switching
      ext_sw = sy_s2 && hi_cnt < SCW'(led_sync_dim_pkg::PER_MAX); // [R10]
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         lo_cnt  <= '0;
         hi_cnt  <= '0;
         edges   <= 2'h0;
         ext_sel <= 1'b0;
         sw_cnt  <= 7'h00;
      end else begin
         lo_cnt  <= next_lo_cnt;
         hi_cnt  <= next_hi_cnt;
         edges   <= next_edges;
         ext_sel <= next_ext_sel;
         sw_cnt  <= next_sw_cnt;
      end
   end

   // Power state control
   led_sync_dim_pkg::ctrl_state_t state, next_state;
   logic [6:0]     en_hi, next_en_hi;
   logic [LPW-1:0] en_lo, next_en_lo;
   logic [SCW-1:0] sd_cnt, next_sd_cnt;
   logic           run_on, next_sw, next_ss;

   always_comb begin
      next_state  = state;
      next_ss     = 1'b0;
      next_en_hi  = en_s2 ? ((en_hi == EN_MIN) ? en_hi : en_hi + 7'h01)
                          : 7'h00;
      next_en_lo  = en_s2 ? '0 : ((en_lo == LP_CYC) ? en_lo
                                                    : en_lo + 1'b1);
      next_sd_cnt = '0;
      case (state)
         led_sync_dim_pkg::ST_IDLE: begin
            // Set pin low blocks start unless a sync clock is present
            if (uv_s2 && en_s2 && en_hi == EN_MIN && !fs_s2 && // [R23]
                (fh_s2 || next_ext_sel)) begin           // [R4] [R5]
               next_state = led_sync_dim_pkg::ST_RUN;
               next_ss    = 1'b1;
            end
         end
         led_sync_dim_pkg::ST_RUN: begin
            if (fs_s2 || loss_low)                       // [R3] [R11]
               next_state = led_sync_dim_pkg::ST_SHDN;
            else if (!uv_s2)
               next_state = led_sync_dim_pkg::ST_IDLE;
         end
         led_sync_dim_pkg::ST_SHDN: begin
            next_sd_cnt = (sd_cnt == RST_CYC) ? sd_cnt : sd_cnt + 1'b1;
            if (sd_cnt == RST_CYC && fh_s2 && !fs_s2 && uv_s2 && en_s2) begin
               next_state = led_sync_dim_pkg::ST_RUN;    // [R14]
               next_ss    = 1'b1;
            end
         end
         led_sync_dim_pkg::ST_LOWPWR: begin
            if (en_s2)
               next_state = led_sync_dim_pkg::ST_IDLE;
         end
         default: next_state = led_sync_dim_pkg::ST_IDLE;
      endcase
      // Long enable low wins over every other state move
      if (en_lo == LP_CYC - 1'b1)                        // [R13]
         next_state = led_sync_dim_pkg::ST_LOWPWR;
      // Only two sync stages plus one output flop: 75 ns to the sinks
      run_on  = next_state == led_sync_dim_pkg::ST_RUN && en_s2; // [R17]
      next_sw = run_on && (next_ext_sel ? ext_sw : int_sw); // [R6] [R12]
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state         <= led_sync_dim_pkg::ST_IDLE;
         en_hi         <= 7'h00;
         en_lo         <= '0;
         sd_cnt        <= '0;
         SW_CLK        <= 1'b0;
         BOOST_EN      <= 1'b0;
         LED_SINK_EN   <= 1'b0;
         DISCONNECT_ON <= 1'b0;
         COMP_FLOAT    <= 1'b1;
         CORE_ALIVE    <= 1'b1;
         SOFT_START    <= 1'b0;
         EXT_CLK_SEL   <= 1'b0;
         CLK_LOSS_SHDN <= 1'b0;
         LOW_POWER     <= 1'b0;
      end else begin
         state         <= next_state;
         en_hi         <= next_en_hi;
         en_lo         <= next_en_lo;
         sd_cnt        <= next_sd_cnt;
         SW_CLK        <= next_sw;
         BOOST_EN      <= run_on;                        // [R15] [R16]
         LED_SINK_EN   <= run_on;                        // [R15] [R16]
         DISCONNECT_ON <= next_state == led_sync_dim_pkg::ST_RUN; // [R12]
         COMP_FLOAT    <= !run_on;                       // [R16]
         CORE_ALIVE    <= next_state != led_sync_dim_pkg::ST_LOWPWR;
         SOFT_START    <= next_ss;                       // [R14]
         EXT_CLK_SEL   <= next_ext_sel;
         CLK_LOSS_SHDN <= next_state == led_sync_dim_pkg::ST_SHDN;
         LOW_POWER     <= next_state == led_sync_dim_pkg::ST_LOWPWR;
      end
   end

   // Trim duty measurement and delayed application
   logic [TWW-1:0] win, next_win, acc, next_acc;
   logic [7:0]     pend, next_pend, next_level;
   logic [TDW-1:0] dly, next_dly;
   logic [7:0]     meas;

   always_comb begin
      next_win   = win + 1'b1;
      next_acc   = acc;
      next_pend  = pend;
      next_dly   = dly;
      next_level = ILED_LEVEL;
      // Inverse of duty: grounded input gives full current
      meas = ~acc[TWW-1 -: led_sync_dim_pkg::LEVEL_W];   // [R19]
      if (&win) begin
         // Current sample opens the next window, so none is lost
         next_acc = {{(TWW-1){1'b0}}, tr_s2};
         if (meas != pend) begin
            next_pend = meas;
            next_dly  = '0;
         end
      end else if (tr_s2 && !(&acc)) begin
         next_acc = acc + 1'b1;
      end
      // New level reaches the sinks only after the hold delay
      if (next_pend == pend && dly != TD_CYC) begin
         next_dly = dly + 1'b1;
         if (dly == TD_CYC - 1'b1)
            next_level = pend;                           // [R22]
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         win        <= '0;
         acc        <= '0;
         pend       <= led_sync_dim_pkg::LEVEL_FULL;
         dly        <= '0;
         ILED_LEVEL <= led_sync_dim_pkg::LEVEL_FULL;
      end else begin
         win        <= next_win;
         acc        <= next_acc;
         pend       <= next_pend;
         dly        <= next_dly;
         ILED_LEVEL <= next_level;
      end
   end
endmodule // led_sync_dim_ctrl

//--- testbench/led_sync_dim_ctrl_chk.sv
// Port assertions for the LED dimming control block
`timescale 1ns/100ps
module led_sync_dim_ctrl_chk #(
   parameter int LOW_POWER_CYC  = 200, // Low power entry time
   parameter int TRIM_DELAY_CYC = 50   // Trim apply delay
) (
   input wire logic REF_CLK,       // Clock
   input wire logic RST_B,         // Reset
   input wire logic EN_PWM,        // Enable
   input wire logic SYNC_IN,       // Sync clock
   input wire logic FREQ_SET_HIGH, // Set pin up
   input wire logic UVLO_OK,       // Supply ok
   input wire logic SW_CLK,        // Switch
   input wire logic BOOST_EN,      // Boost
   input wire logic LED_SINK_EN,   // Sinks
   input wire logic DISCONNECT_ON, // Disconnect
   input wire logic COMP_FLOAT,    // Comp float
   input wire logic CORE_ALIVE,    // Core on
   input wire logic SOFT_START,    // Soft start
   input wire logic EXT_CLK_SEL,   // Ext clock
   input wire logic CLK_LOSS_SHDN, // Shutdown
   input wire logic LOW_POWER      // Low power
);
   logic [8:0] lo_cnt, next_lo_cnt, sw_low, next_sw_low;
   always_comb begin
      next_lo_cnt = (EXT_CLK_SEL && !SYNC_IN) ? lo_cnt + 9'h001 : 9'h000;
      next_sw_low = (BOOST_EN && !SW_CLK) ? sw_low + 9'h001 : 9'h000;
   end
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         lo_cnt <= 9'h000;
         sw_low <= 9'h000;
      end else begin
         lo_cnt <= next_lo_cnt;
         sw_low <= next_sw_low;
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   sequence en_drop; $fell(EN_PWM) && LED_SINK_EN; endsequence
   sequence sink_off; ##[1:20] !LED_SINK_EN; endsequence
   a_en_to_sink: assert property (en_drop |-> sink_off)
      else $error("sinks did not follow enable low");
   a_run_drives: assert property (LED_SINK_EN |->
      BOOST_EN && DISCONNECT_ON && !COMP_FLOAT)
      else $error("run outputs inconsistent");
   a_en_low_off: assert property (!EN_PWM [*8] |->
      !LED_SINK_EN && !BOOST_EN) else $error("drives on with enable low");
   a_low_pwr: assert property (LOW_POWER |->
      !CORE_ALIVE && !BOOST_EN) else $error("low power state wrong");
   a_shdn_off: assert property (CLK_LOSS_SHDN |-> !BOOST_EN &&
      !LED_SINK_EN && !DISCONNECT_ON && !SW_CLK)
      else $error("shutdown left a drive on");
   a_loss_bound: assert property (lo_cnt < 9'h127)
      else $error("sync loss not detected in time");
   a_loss_shdn: assert property ($fell(EXT_CLK_SEL) && !SYNC_IN &&
      $past(LED_SINK_EN) |-> CLK_LOSS_SHDN)
      else $error("low sync loss did not shut down");
   a_pause_max: assert property (sw_low < 9'h168)
      else $error("switching paused too long");
   a_clamp_gap: assert property ($rose(SW_CLK) && !EXT_CLK_SEL |=>
      !($rose(SW_CLK) && !EXT_CLK_SEL) [*8])
      else $error("internal switching too fast");
   a_start_gate: assert property (SOFT_START |->
      $past(UVLO_OK, 3) && ($past(FREQ_SET_HIGH, 3) || EXT_CLK_SEL))
      else $error("start without its conditions");
   a_soft_pulse: assert property (SOFT_START |->
      LED_SINK_EN ##1 !SOFT_START) else $error("soft start pulse wrong");
endmodule // led_sync_dim_ctrl_chk
bind led_sync_dim_ctrl led_sync_dim_ctrl_chk #(
   .LOW_POWER_CYC(LOW_POWER_CYC), .TRIM_DELAY_CYC(TRIM_DELAY_CYC)) chk (
   .REF_CLK(REF_CLK), .RST_B(RST_B), .EN_PWM(EN_PWM), .SYNC_IN(SYNC_IN),
   .FREQ_SET_HIGH(FREQ_SET_HIGH), .UVLO_OK(UVLO_OK), .SW_CLK(SW_CLK),
   .BOOST_EN(BOOST_EN), .LED_SINK_EN(LED_SINK_EN),
   .DISCONNECT_ON(DISCONNECT_ON), .COMP_FLOAT(COMP_FLOAT),
   .CORE_ALIVE(CORE_ALIVE), .SOFT_START(SOFT_START),
   .EXT_CLK_SEL(EXT_CLK_SEL), .CLK_LOSS_SHDN(CLK_LOSS_SHDN),
   .LOW_POWER(LOW_POWER));

//--- testbench/dim_host_model.sv
// Host model: external sync clock and trim PWM source
`timescale 1ns/100ps
module dim_host_model (
   input  wire logic       clk,       // Reference clock
   input  wire logic [1:0] sync_mode, // 0 low, 1 high, 2 run
   input  wire logic       trim_on,   // Trim PWM running
   output logic            sync_out,  // External clock
   output logic            trim_out   // Trim PWM
);
   logic [5:0] cnt = 6'h00;
   always_ff @(posedge clk) cnt <= cnt + 6'h01;
   // 625 kHz, 800 ns phases, 50 percent duty
   always_comb sync_out = (sync_mode == 2'h2) ? cnt[5]
                                              : sync_mode[0];
   // 625 kHz at 25 percent; grounded when unused
   always_comb trim_out = trim_on && (cnt[5:4] == 2'h0);
endmodule // dim_host_model

//--- testbench/test_led_sync_dim_ctrl.sv
// Self-checking bench for the LED dimming control block
`timescale 1ns/100ps
module test_led_sync_dim_ctrl;
   logic       REF_CLK, RST_B, EN_PWM, SYNC_IN, FREQ_SET_HIGH;
   logic       FREQ_SET_SHORT, UVLO_OK, CURRENT_TRIM_PWM, trim_on;
   logic [6:0] FREQ_SET_PERIOD;
   logic [1:0] smode;
   logic       SW_CLK, BOOST_EN, LED_SINK_EN, DISCONNECT_ON, COMP_FLOAT;
   logic       CORE_ALIVE, SOFT_START, EXT_CLK_SEL, CLK_LOSS_SHDN, LOW_POWER;
   logic [7:0] ILED_LEVEL;
   int         fail_count, checks_done;
   led_sync_dim_ctrl #(.LOW_POWER_CYC(200), .TRIM_DELAY_CYC(50)) uut (
      .REF_CLK(REF_CLK), .RST_B(RST_B), .EN_PWM(EN_PWM), .SYNC_IN(SYNC_IN),
      .FREQ_SET_HIGH(FREQ_SET_HIGH), .FREQ_SET_SHORT(FREQ_SET_SHORT),
      .FREQ_SET_PERIOD(FREQ_SET_PERIOD), .UVLO_OK(UVLO_OK),
      .CURRENT_TRIM_PWM(CURRENT_TRIM_PWM), .SW_CLK(SW_CLK),
      .BOOST_EN(BOOST_EN), .LED_SINK_EN(LED_SINK_EN),
      .DISCONNECT_ON(DISCONNECT_ON), .COMP_FLOAT(COMP_FLOAT),
      .CORE_ALIVE(CORE_ALIVE), .SOFT_START(SOFT_START),
      .EXT_CLK_SEL(EXT_CLK_SEL), .CLK_LOSS_SHDN(CLK_LOSS_SHDN),
      .LOW_POWER(LOW_POWER), .ILED_LEVEL(ILED_LEVEL));
   dim_host_model host (.clk(REF_CLK), .sync_mode(smode), .trim_on(trim_on),
      .sync_out(SYNC_IN), .trim_out(CURRENT_TRIM_PWM));
   initial begin
      REF_CLK = 1'b0;
      forever #12.5 REF_CLK = ~REF_CLK;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [7:0] pick(int s);
      case (s)
         0: return 8'(LED_SINK_EN);
         1: return 8'(EXT_CLK_SEL);
         2: return 8'(CLK_LOSS_SHDN);
         3: return 8'(LOW_POWER);
         default: return ILED_LEVEL;
      endcase
   endfunction
   // Bounded wait; a spent bound ends the run
   task automatic wait_for(string what, int s, logic [7:0] v, int lim);
      int n;
      n = 0;
      // First look only once the launching edge has settled
      @(negedge REF_CLK);
      while (pick(s) !== v && n < lim) begin
         @(negedge REF_CLK);
         n++;
      end
      check(what, v, pick(s));
      if (pick(s) !== v) close_out();
   endtask
   task automatic t_start();
      @(posedge REF_CLK) EN_PWM <= 1'b1;
      repeat (100) @(negedge REF_CLK);
      check("sinks, set pin low", 8'h00, 8'(LED_SINK_EN));
      @(posedge REF_CLK) FREQ_SET_HIGH <= 1'b1;
      wait_for("sinks on", 0, 8'h01, 100);
      check("comp float", 8'h00, 8'(COMP_FLOAT));
      check("full level", 8'hFF, ILED_LEVEL);
   endtask
   task automatic t_enable();
      @(posedge REF_CLK) EN_PWM <= 1'b0;
      wait_for("sinks off", 0, 8'h00, 20);
      check("comp floated", 8'h01, 8'(COMP_FLOAT));
      check("core alive", 8'h01, 8'(CORE_ALIVE));
      // Dimming low time is about 20 cycles, under one 40-cycle switch period
      repeat (20) @(negedge REF_CLK);
      @(posedge REF_CLK) EN_PWM <= 1'b1;
      wait_for("sinks back", 0, 8'h01, 20);
   endtask
   task automatic t_period(logic [6:0] p, logic [7:0] exp);
      int n, k, t0, t1;
      logic last;
      k = 0;
      t0 = 0;
      t1 = 0;
      last = 1'b1;
      @(posedge REF_CLK) FREQ_SET_PERIOD <= p;
      repeat (150) @(negedge REF_CLK);
      for (n = 0; n < 400 && k < 2; n++) begin
         @(negedge REF_CLK);
         if (SW_CLK && !last) begin
            k++;
            if (k == 1) t0 = n;
            else t1 = n;
         end
         last = SW_CLK;
      end
      check("switch period", exp, 8'(t1 - t0));
   endtask
   task automatic t_sync();
      @(posedge REF_CLK) smode <= 2'h2;
      wait_for("sync taken", 1, 8'h01, 400);
      check("level steady", 8'hFF, ILED_LEVEL);
      @(posedge REF_CLK) smode <= 2'h1;
      wait_for("fallback", 1, 8'h00, 400);
      check("no shutdown", 8'h00, 8'(CLK_LOSS_SHDN));
      @(posedge REF_CLK) smode <= 2'h2;
      wait_for("sync again", 1, 8'h01, 400);
      @(posedge REF_CLK) smode <= 2'h0;
      FREQ_SET_HIGH <= 1'b0;
      wait_for("loss shutdown", 2, 8'h01, 400);
      check("disconnect open", 8'h00, 8'(DISCONNECT_ON));
      repeat (250) @(negedge REF_CLK);
      check("held down", 8'h01, 8'(CLK_LOSS_SHDN));
      @(posedge REF_CLK) FREQ_SET_HIGH <= 1'b1;
      wait_for("restart", 0, 8'h01, 20);
   endtask
   task automatic t_short();
      @(posedge REF_CLK) FREQ_SET_SHORT <= 1'b1;
      wait_for("short shutdown", 2, 8'h01, 10);
      @(posedge REF_CLK) FREQ_SET_SHORT <= 1'b0;
      wait_for("short restart", 0, 8'h01, 400);
   endtask
   task automatic t_supply();
      @(posedge REF_CLK) UVLO_OK <= 1'b0;
      wait_for("supply low", 0, 8'h00, 10);
      @(posedge REF_CLK) FREQ_SET_HIGH <= 1'b0;
      smode <= 2'h2;
      repeat (20) @(negedge REF_CLK);
      check("start, supply low", 8'h00, 8'(LED_SINK_EN));
      @(posedge REF_CLK) UVLO_OK <= 1'b1;
      wait_for("start on sync", 0, 8'h01, 400);
      @(posedge REF_CLK) FREQ_SET_HIGH <= 1'b1;
      smode <= 2'h1;
      wait_for("sync released", 1, 8'h00, 400);
   endtask
   task automatic t_trim();
      @(posedge REF_CLK) trim_on <= 1'b1;
      repeat (50) @(negedge REF_CLK);
      check("level delayed", 8'hFF, ILED_LEVEL);
      wait_for("trimmed level", 4, 8'hBF, 10000);
      @(posedge REF_CLK) trim_on <= 1'b0;
      wait_for("untrimmed", 4, 8'hFF, 10000);
   endtask
   task automatic t_low_power();
      @(posedge REF_CLK) EN_PWM <= 1'b0;
      wait_for("low power", 3, 8'h01, 300);
      check("core off", 8'h00, 8'(CORE_ALIVE));
      @(posedge REF_CLK) EN_PWM <= 1'b1;
      wait_for("wake", 0, 8'h01, 100);
   endtask
   initial begin
      fail_count = 0;
      checks_done = 0;
      RST_B = 1'b0;
      EN_PWM = 1'b0;
      FREQ_SET_HIGH = 1'b0;
      FREQ_SET_SHORT = 1'b0;
      UVLO_OK = 1'b1;
      FREQ_SET_PERIOD = 7'h28;
      smode = 2'h0;
      trim_on = 1'b0;
      repeat (4) @(posedge REF_CLK);
      RST_B <= 1'b1;
      @(negedge REF_CLK);
      check("reset level", 8'hFF, ILED_LEVEL);
      check("reset comp", 8'h01, 8'(COMP_FLOAT));
      t_start();
      t_enable();
      t_period(7'h05, 8'h0C);
      t_period(7'h28, 8'h28);
      t_period(7'h64, 8'h44);
      t_sync();
      t_short();
      t_supply();
      t_trim();
      t_low_power();
      close_out();
   end
endmodule // test_led_sync_dim_ctrl
